/* rtl/tec_ctrl.sv */
// Transactional execution control: restricted regions, lock elision,
// feature report, conflict-driven aborts and restart redirection.
// Assumes one retired instruction per cycle and static support straps.
`timescale 1ns/1ps
`include "tec_params.svh"
module tec_ctrl import tec_pkg::*; (
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   cfg_hle_sup,
  input  wire logic   cfg_rtm_sup,
  input  wire logic   cfg_ldtrk_sup,
  input  wire logic   ins_valid,
  input  tec_op_type  ins_op,
  input  wire logic [7:0]  ins_imm,
  input  wire logic [31:0] ins_pc,
  input  wire logic [31:0] ins_next_pc,
  input  wire logic [31:0] ins_offset,
  input  wire logic [31:0] ins_leaf,
  input  wire logic [31:0] ins_addr,
  input  wire logic [1:0]  ins_size,
  input  wire logic [31:0] ins_wdata,
  input  wire logic [31:0] ins_mdata,
  input  wire logic   ins_acq_hint,
  input  wire logic   ins_rel_hint,
  input  wire logic   snp_valid,
  input  wire logic   snp_wr,
  input  wire logic [31:0] snp_addr,
  output logic        ud_fault_r,
  output logic        redirect_r,
  output logic [31:0] redirect_pc_r,
  output logic        noelide_r,
  output logic        acc_wr_r,
  output logic [31:0] acc_data_r,
  output logic        commit_r,
  output logic        discard_r,
  output logic        in_txn_r,
  output logic        test_done_r,
  output logic        test_result_r,
  output logic        feat_valid_r,
  output logic [31:0] feat_b_r,
  output logic [31:0] feat_d_r,
  output logic        fwd_valid_r,
  output logic [31:0] fwd_data_r
);
  localparam int CW = $clog2(`TEC_LOCK_LIMIT + 1);

  // ==========================================================
  // State
  tec_mode_type mode_r,  mode_nxt;
  logic [3:0]   rtm_nest_r, rtm_nest_nxt;
  logic [3:0]   hle_nest_r, hle_nest_nxt;
  logic [31:0]  fallback_r, fallback_nxt;
  logic [31:0]  hle_pc_r,   hle_pc_nxt;
  logic         noelide_pend_r, noelide_pend_nxt;
  logic         commit_nxt;

  // ==========================================================
  // Decode
  wire v       = ins_valid;
  wire in_txn  = (mode_r != TEC_IDLE);
  wire m_rtm   = (mode_r == TEC_RTM);
  wire m_hle   = (mode_r == TEC_HLE);
  wire rtm_op  = v && (ins_op == OP_BEGIN || ins_op == OP_END || ins_op == OP_ABORT);
  wire ld_op   = v && (ins_op == OP_SUSLD || ins_op == OP_RESLD);
  wire tst_op  = v && ins_op == OP_TEST;
  wire ud_rtm  = rtm_op && !cfg_rtm_sup;
  wire ud_tst  = tst_op && !(cfg_hle_sup || cfg_rtm_sup);
  wire ud_ld   = ld_op && !cfg_ldtrk_sup;
  wire ud_any  = ud_rtm || ud_tst || ud_ld;
  wire beg     = v && ins_op == OP_BEGIN && cfg_rtm_sup;
  wire fin     = v && ins_op == OP_END && cfg_rtm_sup && m_rtm;
  wire xab     = v && ins_op == OP_ABORT && cfg_rtm_sup && in_txn;
  wire is_ld   = v && ins_op == OP_LOAD;
  wire is_st   = v && ins_op == OP_STORE;
  wire is_lk   = v && ins_op == OP_LOCK;

  // Hints are ignored inside restricted regions and on replay
  wire hle_ok  = cfg_hle_sup && !noelide_pend_r && !m_rtm;
  wire acq     = is_lk && ins_acq_hint && hle_ok;
  wire acq_rpl = is_lk && ins_acq_hint && noelide_pend_r;
  wire rel     = is_st && ins_rel_hint && m_hle;

  // ==========================================================
  // Elided lock table
  logic        lt_hit;
  logic [1:0]  lt_size;
  logic [31:0] lt_orig;
  logic [31:0] lt_acq;
  logic        lt_full;
  logic [CW-1:0] lt_cnt;

  wire crosses  = tec_cross(ins_addr, ins_size);
  wire acq_rec  = acq && lt_hit;
  wire acq_bad  = acq && crosses;
  wire acq_deep = acq && hle_nest_r == `TEC_HLE_NEST_MAX;
  wire acq_go   = acq && !acq_rec && !acq_bad && !acq_deep;
  wire acq_el   = acq_go && !lt_full;
  wire acq_ws   = acq_go && lt_full;
  wire rel_bad  = rel && lt_hit
                  && (lt_size != ins_size || ins_wdata != lt_orig);
  wire rel_ok   = rel && lt_hit && !rel_bad;
  wire rel_last = rel && hle_nest_r == 4'h1;
  wire matched  = rel_ok ? (lt_cnt == CW'(1)) : (lt_cnt == '0);
  wire st_lock  = is_st && !ins_rel_hint && m_hle && lt_hit;
  wire fwd      = is_ld && m_hle && lt_hit;

  // ==========================================================
  // Abort causes
  logic set_conf;
  logic set_ovf;
  wire ab_set  = in_txn && (set_conf || set_ovf);
  wire ab_rnst = beg && m_rtm && rtm_nest_r == `TEC_RTM_NEST_MAX;
  wire ab_hle  = m_hle && (acq_rec || acq_bad || acq_deep || rel_bad || st_lock
                 || (rel_last && !matched) || beg || xab);
  wire abort   = ab_set || (m_rtm && (xab || ab_rnst)) || ab_hle;

  wire [31:0] st_base = xab ? ({ins_imm, 24'h00_0000} | `TEC_ST_EXPLICIT)
                      : set_conf ? `TEC_ST_CONFLICT
                      : set_ovf  ? `TEC_ST_OVERFLOW : 32'h0000_0000;
  wire [31:0] status  = st_base | ((rtm_nest_r > 4'h1) ? `TEC_ST_NESTED : 32'h0000_0000);

  // Elided lock goes to the read-set, other writes except a matching release to the write-set
  wire mem_op  = is_ld || is_st || is_lk;
  wire add_v   = (in_txn || acq_el) && mem_op && !abort && !rel_ok;
  wire add_wr  = is_st || (is_lk && !acq_el);
  wire set_clr = abort || commit_nxt;

  // ==========================================================
  // Region sequencing
  always_comb begin
    mode_nxt         = mode_r;
    rtm_nest_nxt     = rtm_nest_r;
    hle_nest_nxt     = hle_nest_r;
    fallback_nxt     = fallback_r;
    hle_pc_nxt       = hle_pc_r;
    noelide_pend_nxt = noelide_pend_r && !acq_rpl;
    commit_nxt       = 1'b0;
    if (abort) begin
      mode_nxt     = TEC_IDLE;
      rtm_nest_nxt = 4'h0;
      hle_nest_nxt = 4'h0;
      if (m_hle) noelide_pend_nxt = 1'b1;
    end else begin
      unique case (mode_r)
        TEC_IDLE: begin
          if (beg) begin
            mode_nxt     = TEC_RTM;
            rtm_nest_nxt = 4'h1;
            fallback_nxt = ins_next_pc + ins_offset;
          end else if (acq_el) begin
            mode_nxt     = TEC_HLE;
            hle_nest_nxt = 4'h1;
            hle_pc_nxt   = ins_pc;
          end
        end
        TEC_RTM: begin
          if (beg) rtm_nest_nxt = rtm_nest_r + 4'h1;
          else if (fin) begin
            rtm_nest_nxt = rtm_nest_r - 4'h1;
            if (rtm_nest_r == 4'h1) begin
              mode_nxt   = TEC_IDLE;
              commit_nxt = 1'b1;
            end
          end
        end
        TEC_HLE: begin
          if (acq_el || acq_ws) hle_nest_nxt = hle_nest_r + 4'h1;
          else if (rel) begin
            hle_nest_nxt = hle_nest_r - 4'h1;
            if (rel_last) begin
              mode_nxt   = TEC_IDLE;
              commit_nxt = 1'b1;
            end
          end
        end
        default: mode_nxt = TEC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_r         <= TEC_IDLE;
      rtm_nest_r     <= 4'h0;
      hle_nest_r     <= 4'h0;
      fallback_r     <= 32'h0000_0000;
      hle_pc_r       <= 32'h0000_0000;
      noelide_pend_r <= 1'b0;
    end else begin
      mode_r         <= mode_nxt;
      rtm_nest_r     <= rtm_nest_nxt;
      hle_nest_r     <= hle_nest_nxt;
      fallback_r     <= fallback_nxt;
      hle_pc_r       <= hle_pc_nxt;
      noelide_pend_r <= noelide_pend_nxt;
    end
  end

  wire        fq_hit = v && ins_op == OP_FQUERY && ins_leaf == `TEC_FEAT_LEAF;
  wire [31:0] feat_b = (32'(cfg_hle_sup) << `TEC_HLE_BIT)
                     | (32'(cfg_rtm_sup) << `TEC_RTM_BIT);
  wire [31:0] feat_d = 32'(cfg_ldtrk_sup) << `TEC_LDTRK_BIT;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ud_fault_r    <= 1'b0;
      redirect_r    <= 1'b0;
      redirect_pc_r <= 32'h0000_0000;
      noelide_r     <= 1'b0;
      acc_wr_r      <= 1'b0;
      acc_data_r    <= 32'h0000_0000;
      commit_r      <= 1'b0;
      discard_r     <= 1'b0;
      in_txn_r      <= 1'b0;
      test_done_r   <= 1'b0;
      test_result_r <= 1'b0;
      feat_valid_r  <= 1'b0;
      feat_b_r      <= 32'h0000_0000;
      feat_d_r      <= 32'h0000_0000;
      fwd_valid_r   <= 1'b0;
      fwd_data_r    <= 32'h0000_0000;
    end else begin
      ud_fault_r    <= ud_any;
      redirect_r    <= abort;
      redirect_pc_r <= m_hle ? hle_pc_r : fallback_r;
      noelide_r     <= abort && m_hle;
      acc_wr_r      <= abort && m_rtm;
      acc_data_r    <= status;
      commit_r      <= commit_nxt;
      discard_r     <= abort;
      in_txn_r      <= mode_nxt != TEC_IDLE;
      test_done_r   <= tst_op && !ud_tst;
      test_result_r <= in_txn;
      feat_valid_r  <= v && ins_op == OP_FQUERY;
      feat_b_r      <= fq_hit ? feat_b : 32'h0000_0000;
      feat_d_r      <= fq_hit ? feat_d : 32'h0000_0000;
      fwd_valid_r   <= fwd;
      fwd_data_r    <= lt_acq;
    end
  end

  // ==========================================================
  // Submodules
  tec_locktab u_locks (
    .clk       (clk),
    .rstn      (rstn),
    .clr       (set_clr),
    .ins_v     (acq_el && !abort),
    .ins_addr  (ins_addr),
    .ins_size  (ins_size),
    .ins_orig  (ins_mdata),
    .ins_acq   (ins_wdata),
    .rel_v     (rel_ok && !abort),
    .look_addr (ins_addr),
    .hit       (lt_hit),
    .hit_size  (lt_size),
    .hit_orig  (lt_orig),
    .hit_acq   (lt_acq),
    .full      (lt_full),
    .cnt       (lt_cnt)
  );

  // Line granularity means neighbours of a lock can false-share
  tec_lineset u_sets (
    .clk        (clk),
    .rstn       (rstn),
    .clr        (set_clr),
    .add_v      (add_v),
    .add_wr     (add_wr),
    .add_line   (tec_line(ins_addr)),
    .snp_v      (snp_valid),
    .snp_wr     (snp_wr),
    .snp_line   (tec_line(snp_addr)),
    .conflict_r (set_conf),
    .overflow_r (set_ovf)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_abort_txn;
    m_rtm && xab && !ab_set;
  endsequence

  ud_restricted_a: assert property (ud_rtm |=> ud_fault_r)
    else $error("restricted op without support did not fault");
  ud_query_a: assert property (tst_op |=> (ud_fault_r == $past(ud_tst)))
    else $error("status query fault wrong");
  ud_ldtrk_a: assert property (ud_ld |=> ud_fault_r)
    else $error("load tracking op without support did not fault");
  abort_imm_a: assert property (s_abort_txn |=> acc_wr_r && acc_data_r[31:24] == $past(ins_imm))
    else $error("explicit abort immediate lost");
  restart_pc_a: assert property (abort && m_rtm |=> redirect_r && redirect_pc_r == $past(fallback_r))
    else $error("abort did not redirect to fallback");
  no_elide_a: assert property (!cfg_hle_sup |-> !m_hle)
    else $error("elision entered without support");
  query_result_a: assert property (tst_op && !ud_tst |=> test_done_r && test_result_r == $past(in_txn))
    else $error("status query result wrong");
  hle_enter_a: assert property (mode_r == TEC_IDLE && acq_el |=> m_hle && hle_nest_r == 4'h1)
    else $error("elided acquire did not open region");
  commit_zero_a: assert property (commit_r |-> mode_r == TEC_IDLE && hle_nest_r == 4'h0 && rtm_nest_r == 4'h0)
    else $error("commit with nonzero nesting");
  lock_fwd_a: assert property (fwd |=> fwd_valid_r && fwd_data_r == $past(lt_acq))
    else $error("elided lock read not forwarded");
  wset_stay_a: assert property (m_hle && acq_ws && !abort |=> m_hle)
    else $error("over-limit acquire left transactional mode");
endmodule // tec_ctrl

/* rtl/tec_params.svh */
// Constants of the transactional execution control block.
// Assumes inclusion by the package and by every design module.
`ifndef TEC_PARAMS_SVH
`define TEC_PARAMS_SVH
`define TEC_FEAT_LEAF    32'h0000_0007
`define TEC_HLE_BIT      4
`define TEC_RTM_BIT      11
`define TEC_LDTRK_BIT    16
`define TEC_LINE_BITS    6
`define TEC_LINE_BYTES   7'h40
`define TEC_SET_DEPTH    8
`define TEC_LOCK_LIMIT   2
`define TEC_HLE_NEST_MAX 4'h7
`define TEC_RTM_NEST_MAX 4'h7
`define TEC_ST_EXPLICIT  32'h0000_0001
`define TEC_ST_CONFLICT  32'h0000_0004
`define TEC_ST_OVERFLOW  32'h0000_0008
`define TEC_ST_NESTED    32'h0000_0020
`endif

/* rtl/tec_pkg.sv */
// Types and shared helpers of the transactional execution control block.
// Assumes tec_params.svh is on the include path.
package tec_pkg;
  `include "tec_params.svh"

  typedef enum logic [3:0] {
    OP_NOP    = 4'h0,
    OP_BEGIN  = 4'h1,
    OP_END    = 4'h2,
    OP_ABORT  = 4'h3,
    OP_TEST   = 4'h4,
    OP_SUSLD  = 4'h5,
    OP_RESLD  = 4'h6,
    OP_FQUERY = 4'h7,
    OP_LOAD   = 4'h8,
    OP_STORE  = 4'h9,
    OP_LOCK   = 4'hA
  } tec_op_type;

  typedef enum logic [1:0] {
    TEC_IDLE = 2'b00,
    TEC_RTM  = 2'b01,
    TEC_HLE  = 2'b10
  } tec_mode_type;

  typedef logic [31-`TEC_LINE_BITS:0] tec_line_type;

  function automatic tec_line_type tec_line(input logic [31:0] a);
    return a[31:`TEC_LINE_BITS];
  endfunction

  // True when an access of 1 << sz bytes runs past its cache line
  function automatic logic tec_cross(input logic [31:0] a, input logic [1:0] sz);
    logic [6:0] endb;
    endb = {1'b0, a[`TEC_LINE_BITS-1:0]} + (7'h01 << sz);
    return endb > `TEC_LINE_BYTES;
  endfunction
endpackage

/* rtl/tec_lineset.sv */
// Read-set and write-set of the running region, one entry per cache line.
// Assumes adds and snoops arrive as single-cycle strobes in the core clock.
`timescale 1ns/1ps
`include "tec_params.svh"
module tec_lineset import tec_pkg::*; (
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   clr,
  input  wire logic   add_v,
  input  wire logic   add_wr,
  input  tec_line_type add_line,
  input  wire logic   snp_v,
  input  wire logic   snp_wr,
  input  tec_line_type snp_line,
  output logic        conflict_r,
  output logic        overflow_r
);
  localparam int DEPTH = `TEC_SET_DEPTH;
  localparam int IW    = $clog2(DEPTH);

  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] rd_r;
  logic [DEPTH-1:0] wr_r;
  tec_line_type     tag_r [DEPTH];
  logic [DEPTH-1:0] hit;
  logic             conf_v;
  logic             has_free;
  logic [IW-1:0]    free_idx;

  // Remote read clashes with our writes, remote write with anything
  always_comb begin
    hit      = '0;
    conf_v   = 1'b0;
    has_free = 1'b0;
    free_idx = '0;
    for (int i = 0; i < DEPTH; i++) begin
      hit[i] = vld_r[i] && (tag_r[i] == add_line);
      if (vld_r[i] && tag_r[i] == snp_line && (wr_r[i] || (snp_wr && rd_r[i])))
        conf_v = 1'b1;
      if (!vld_r[i] && !has_free) begin
        has_free = 1'b1;
        free_idx = IW'(i);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vld_r <= '0;
      rd_r  <= '0;
      wr_r  <= '0;
      for (int i = 0; i < DEPTH; i++) tag_r[i] <= '0;
    end else if (clr) begin
      vld_r <= '0;
      rd_r  <= '0;
      wr_r  <= '0;
    end else if (add_v && |hit) begin
      rd_r <= rd_r | (hit & {DEPTH{!add_wr}});
      wr_r <= wr_r | (hit & {DEPTH{add_wr}});
    end else if (add_v && has_free) begin
      vld_r[free_idx] <= 1'b1;
      rd_r[free_idx]  <= !add_wr;
      wr_r[free_idx]  <= add_wr;
      tag_r[free_idx] <= add_line;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conflict_r <= 1'b0;
      overflow_r <= 1'b0;
    end else begin
      conflict_r <= snp_v && conf_v && !clr;
      overflow_r <= add_v && !clr && !(|hit) && !has_free;
    end
  end
endmodule // tec_lineset

/* rtl/tec_locktab.sv */
// Table of locks currently elided, looked up by lock address.
// Assumes at most one insert or one release per cycle.
`timescale 1ns/1ps
`include "tec_params.svh"
module tec_locktab import tec_pkg::*; #(
  localparam int N  = `TEC_LOCK_LIMIT,
  localparam int IW = (N > 1) ? $clog2(N) : 1,
  localparam int CW = $clog2(N + 1)
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          clr,
  input  wire logic          ins_v,
  input  wire logic [31:0]   ins_addr,
  input  wire logic [1:0]    ins_size,
  input  wire logic [31:0]   ins_orig,
  input  wire logic [31:0]   ins_acq,
  input  wire logic          rel_v,
  input  wire logic [31:0]   look_addr,
  output logic               hit,
  output logic [1:0]         hit_size,
  output logic [31:0]        hit_orig,
  output logic [31:0]        hit_acq,
  output logic               full,
  output logic [CW-1:0]      cnt
);
  logic [N-1:0]  vld_r;
  logic [31:0]   addr_r [N];
  logic [1:0]    size_r [N];
  logic [31:0]   orig_r [N];
  logic [31:0]   acq_r  [N];
  logic [IW-1:0] hit_idx;
  logic [IW-1:0] free_idx;

  always_comb begin
    hit      = 1'b0;
    hit_idx  = '0;
    free_idx = '0;
    full     = 1'b1;
    cnt      = '0;
    for (int i = 0; i < N; i++) begin
      if (vld_r[i] && addr_r[i] == look_addr && !hit) begin
        hit     = 1'b1;
        hit_idx = IW'(i);
      end
      if (!vld_r[i] && full) begin
        full     = 1'b0;
        free_idx = IW'(i);
      end
      cnt = cnt + CW'(vld_r[i]);
    end
    hit_size = size_r[hit_idx];
    hit_orig = orig_r[hit_idx];
    hit_acq  = acq_r[hit_idx];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vld_r <= '0;
      for (int i = 0; i < N; i++) begin
        addr_r[i] <= '0;
        size_r[i] <= '0;
        orig_r[i] <= '0;
        acq_r[i]  <= '0;
      end
    end else if (clr) begin
      vld_r <= '0;
    end else if (rel_v && hit) begin
      vld_r[hit_idx] <= 1'b0;
    end else if (ins_v && !full) begin
      vld_r[free_idx]  <= 1'b1;
      addr_r[free_idx] <= ins_addr;
      size_r[free_idx] <= ins_size;
      orig_r[free_idx] <= ins_orig;
      acq_r[free_idx]  <= ins_acq;
    end
  end
endmodule // tec_locktab

/* test/tec_remote.sv */
// Far-side logical processor: issues one remote access on request.
// Assumes go is a one-cycle request launched just after a core clock edge.
`timescale 1ns/1ps
module tec_remote (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        go_wr,
  input  wire logic [31:0] go_addr,
  output logic             snp_valid,
  output logic             snp_wr,
  output logic [31:0]      snp_addr
);
  // ====
  // Access pulse
  initial snp_valid = 1'b0;
  initial snp_wr = 1'b0;
  initial snp_addr = 32'h5A5A_A5A5;
  // Idle address churns so the block can never lean on a stale value
  always @(posedge clk) begin
    snp_valid <= go;
    snp_wr    <= go & go_wr;
    snp_addr  <= go ? go_addr : ~snp_addr;
  end
endmodule // tec_remote

/* test/tb.sv */
// Self-checking bench of tec_ctrl: the driver notes results, a watcher compares.
// Assumes tec_remote as the remote processor and tec_pkg compiled first.
`timescale 1ns/1ps
`define CHK(g,e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end
module tb import tec_pkg::*;;
  logic        clk = 0, rstn = 0, lock_elision_mode = 1, restricted_txn_mode = 1, ldt = 1, vld = 0, acq = 0, rel = 0;
  logic        go = 0, go_wr = 0, snp_valid, snp_wr, ud, rd, ne, aw, cm, ds, it, td, tr;
  logic        fv, wv;
  tec_op_type  op = OP_NOP;
  logic [31:0] pc = 32'h1000, a = 0, w = 0, m = 0, go_addr = 0, base, x, k, r;
  logic [31:0] snp_addr, rpc, acc, fb, fd, fwd;
  logic [39:0] exp_q[$];
  int          bad_count = 0, check_count = 0;
  always #5 clk = ~clk;
  tec_ctrl uut (.clk(clk), .rstn(rstn), .cfg_hle_sup(lock_elision_mode), .cfg_rtm_sup(restricted_txn_mode),
    .cfg_ldtrk_sup(ldt), .ins_valid(vld), .ins_op(op), .ins_imm(w[7:0]), .ins_pc(pc),
    .ins_next_pc(pc + 32'h4), .ins_offset(a), .ins_leaf(a), .ins_addr(a), .ins_size(2'h2),
    .ins_wdata(w), .ins_mdata(m), .ins_acq_hint(acq), .ins_rel_hint(rel),
    .snp_valid(snp_valid), .snp_wr(snp_wr), .snp_addr(snp_addr), .ud_fault_r(ud),
    .redirect_r(rd), .redirect_pc_r(rpc), .noelide_r(ne), .acc_wr_r(aw), .acc_data_r(acc),
    .commit_r(cm), .discard_r(ds), .in_txn_r(it), .test_done_r(td), .test_result_r(tr),
    .feat_valid_r(fv), .feat_b_r(fb), .feat_d_r(fd), .fwd_valid_r(wv), .fwd_data_r(fwd));
  tec_remote remote (.clk(clk), .go(go), .go_wr(go_wr), .go_addr(go_addr),
    .snp_valid(snp_valid), .snp_wr(snp_wr), .snp_addr(snp_addr));
  // ====
  // Driver tasks
  task automatic iss(tec_op_type o, logic [31:0] va, vw = 0, vm = 0, logic [1:0] h = 0);
    @(posedge clk);
    #1;
    pc = pc + 32'h4;
    vld = 1;
    op = o;
    a = va;
    w = vw;
    m = vm;
    {acq, rel} = h;
  endtask
  task automatic idle(int n);
    @(posedge clk);
    #1;
    vld = 0;
    repeat (n) @(posedge clk);
  endtask
  task automatic snoop(logic wr, logic [31:0] ad);
    @(posedge clk);
    #1;
    {go, go_wr, go_addr} = {1'b1, wr, ad};
    @(posedge clk);
    #1;
    go = 0;
  endtask
  function automatic void ex(logic [39:0] v);
    exp_q.push_back(v);
  endfunction
  task automatic print_verdict;
    if (exp_q.size() != 0) bad_count++;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ====
  // Watcher: oldest note against each result as it appears
  task automatic take(logic [39:0] got);
    logic [39:0] e;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : ~got;
    `CHK(got, e)
  endtask
  always @(negedge clk) if (rstn) begin
    if (ud) take({8'h1, 32'h0});
    if (rd) take({6'h2, ds, ne, rpc});
    if (aw) take({8'h3, acc});
    if (cm) take({8'h4, 32'h0});
    if (wv) take({8'h5, fwd});
    if (td) take({8'h6, 31'h0, tr});
    if (fv) take({8'h7, fb});
    if (fv) take({8'h8, fd});
  end
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    print_verdict;
  end
  // ====
  // Scenarios
  initial begin
    void'($urandom(32'hB5CF_D376));
    base = $urandom & 32'hFFFF_F000;
    x = $urandom & 32'h0000_FFFC;
    k = $urandom;
    repeat (16) @(posedge clk);
    #1 rstn = 1;
    iss(OP_FQUERY, 32'h7); ex({8'h7, 32'h0000_0810}); ex({8'h8, 32'h0001_0000});
    iss(OP_FQUERY, x | 32'h8); ex({8'h7, 32'h0}); ex({8'h8, 32'h0});
    iss(OP_TEST, 0); ex({8'h6, 32'h0});
    // Inner begin must leave the outer fallback in place
    iss(OP_BEGIN, x); r = pc + 32'h4 + x;
    iss(OP_BEGIN, 32'h40); iss(OP_END, 0); iss(OP_TEST, 0); ex({8'h6, 32'h1});
    iss(OP_ABORT, 0, k); ex({6'h2, 2'b10, r}); ex({8'h3, k[7:0], 24'h1});
    idle(2);
    iss(OP_END, 0); iss(OP_ABORT, 0, k); iss(OP_TEST, 0); ex({8'h6, 32'h0});
    iss(OP_BEGIN, x); iss(OP_BEGIN, x); iss(OP_END, 0); iss(OP_END, 0); ex({8'h4, 32'h0});
    iss(OP_BEGIN, x); r = pc + 32'h4 + x;
    iss(OP_LOAD, base + 32'h100); idle(1);
    snoop(1, base + 32'h108); ex({6'h2, 2'b10, r}); ex({8'h3, 32'h4}); idle(4);
    iss(OP_LOCK, base, 1, 0, 2'b10); iss(OP_LOAD, base); ex({8'h5, 32'h1});
    iss(OP_TEST, 0); ex({8'h6, 32'h1});
    // Release restores the pre-acquire value at the same size
    iss(OP_STORE, base, 0, 0, 2'b01); ex({8'h4, 32'h0});
    iss(OP_LOCK, base, 1, 0, 2'b10); r = pc;
    iss(OP_LOCK, base + 32'h40, 1, 0, 2'b10); iss(OP_LOCK, base + 32'h80, 1, 0, 2'b10);
    iss(OP_TEST, 0); ex({8'h6, 32'h1}); idle(1);
    snoop(0, base + 32'h84); ex({6'h2, 2'b11, r}); idle(4);
    // First acquire after an elision abort runs plainly
    iss(OP_LOCK, base, 1, 0, 2'b10); iss(OP_TEST, 0); ex({8'h6, 32'h0});
    iss(OP_STORE, base, 0); iss(OP_LOCK, base, 1, 0, 2'b10); r = pc;
    iss(OP_STORE, base, 1); ex({6'h2, 2'b11, r}); idle(4);
    // Replayed acquire first, then a freed slot lets a third lock be elided
    iss(OP_LOCK, base, 1, 0, 2'b10); iss(OP_LOCK, base, 1, 0, 2'b10);
    iss(OP_LOCK, base + 32'h40, 2, 0, 2'b10); iss(OP_STORE, base + 32'h40, 0, 0, 2'b01);
    iss(OP_LOCK, base + 32'h80, 3, 0, 2'b10); iss(OP_LOAD, base + 32'h80); ex({8'h5, 32'h3});
    iss(OP_STORE, base + 32'h80, 0, 0, 2'b01); iss(OP_STORE, base, 0, 0, 2'b01); ex({8'h4, 32'h0});
    // Eighth nested acquire passes the nest limit
    iss(OP_LOCK, base, 1, 0, 2'b10); r = pc;
    for (int i = 1; i < 8; i++) iss(OP_LOCK, base + 32'(i) * 32'h40, 1, 0, 2'b10);
    ex({6'h2, 2'b11, r}); idle(4);
    #1 rstn = 0;
    {lock_elision_mode, restricted_txn_mode, ldt} = 3'b000;
    repeat (16) @(posedge clk);
    #1 rstn = 1;
    for (int i = 1; i < 7; i++) begin
      iss(tec_op_type'(4'(i)), 0);
      ex({8'h1, 32'h0});
    end
    iss(OP_FQUERY, 32'h7); ex({8'h7, 32'h0}); ex({8'h8, 32'h0});
    iss(OP_LOCK, base, 1, 0, 2'b10); idle(1);
    #1 `CHK(it, 1'b0)
    idle(2);
    print_verdict;
  end
endmodule // tb
